// ==== src/level_sync.sv ====
// Registered sample of the two pin levels
`timescale 1ns/100ps
`default_nettype none
module level_sync (
    // Clock and reset
    input  wire  logic       clk,
    input  wire  logic       arst_n,
    // Pins
    input  wire  logic [1:0] pinIn,
    input  wire  logic [1:0] inputEn,
    // Sampled levels
    output logic [1:0]       level
);
    typedef struct packed {
        logic [1:0] level;
    } st_t;
    st_t state_ff;
    st_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        // Disabled inputs read low so oscillator swing is never seen
        nxt_state.level = pinIn & inputEn; // R1
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
    assign level = state_ff.level;
endmodule : level_sync
`default_nettype wire

// ==== src/port_in_pkg.sv ====
// Package with register map, field layout and types of the two-bit input port
package port_in_pkg;
    // ==========================================================
    // Register word indices (0xf208, 0xf20a, 0xf20b); byte addresses append two zero bits, so all are word aligned
    localparam logic [15:0] IDX_INPUT_LEVEL = 16'hf208;
    localparam logic [15:0] IDX_TERM_LOW    = 16'hf20a;
    localparam logic [15:0] IDX_TERM_HIGH   = 16'hf20b;
    localparam int          ADDR_W          = 18;
    localparam logic [17:0] ADDR_INPUT_LEVEL = {IDX_INPUT_LEVEL, 2'b00};
    localparam logic [17:0] ADDR_TERM_LOW    = {IDX_TERM_LOW, 2'b00};
    localparam logic [17:0] ADDR_TERM_HIGH   = {IDX_TERM_HIGH, 2'b00};
    localparam logic [7:0]  TERM_RESET       = 8'h00;
    localparam logic [31:0] READ_ZERO        = 32'h00000000;
    localparam int          PIN_N            = 2;
    localparam int          PIN_ZERO_BIT     = 0;
    localparam int          PIN_ONE_BIT      = 1;

    // ==========================================================
    // Oscillator mode field values
    localparam logic [1:0] OSC_MODE_PORT  = 2'b00;
    localparam logic [1:0] OSC_MODE_XTAL  = 2'b01;
    localparam logic [1:0] OSC_MODE_EXTCK = 2'b10;

    // Termination kinds, Gray along none->down->up
    typedef enum logic [1:0] {
        TERM_HIZ  = 2'b00,
        TERM_DOWN = 2'b01,
        TERM_UP   = 2'b11
    } term_t;

    // Per-pin pad control
    typedef struct packed {
        logic [1:0] pullUpEn;
        logic [1:0] pullDownEn;
        logic [1:0] inputEn;
        logic       drivePinOne;
        logic       clkFromPin0;
    } pad_ctrl_t;

    // Select registers
    typedef struct packed {
        logic [1:0] termLow;
        logic [1:0] termHigh;
    } term_regs_t;

    // APB request
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_t;

    function automatic term_t decode_term(input logic hi, input logic lo);
        case ({hi, lo})
            2'b01:   decode_term = TERM_DOWN;
            2'b10:   decode_term = TERM_UP;
            default: decode_term = TERM_HIZ;
        endcase
    endfunction : decode_term
endpackage : port_in_pkg

// ==== src/term_decode.sv ====
// Pad control decode from termination selects and oscillator mode
`timescale 1ns/100ps
`default_nettype none
module term_decode (
    // Register state
    input  wire  port_in_pkg::term_regs_t  regs,
    input  wire  logic [1:0]               hsOscModeSel,
    // Pad control
    output var   port_in_pkg::pad_ctrl_t   pad
);
    port_in_pkg::term_t t;
    logic xtal;
    logic extck;
    assign xtal  = (hsOscModeSel == port_in_pkg::OSC_MODE_XTAL);
    assign extck = (hsOscModeSel == port_in_pkg::OSC_MODE_EXTCK);

    always_comb begin
        pad = '0;
        t = port_in_pkg::TERM_HIZ;
        for (int i = 0; i < port_in_pkg::PIN_N; i++) begin
            t = port_in_pkg::decode_term(regs.termHigh[i], regs.termLow[i]); // R3
            // Resonator pins lose pulls and input use
            pad.pullUpEn[i]   = (t == port_in_pkg::TERM_UP) && !xtal;   // R6
            pad.pullDownEn[i] = (t == port_in_pkg::TERM_DOWN) && !xtal; // R6
            pad.inputEn[i]    = !xtal;                                   // R6
        end
        // Pin 0 is the clock in external mode; pin 1 stays an input
        if (extck) begin
            pad.inputEn[port_in_pkg::PIN_ZERO_BIT] = 1'b0; // R8
        end
        pad.drivePinOne = xtal;  // R7
        pad.clkFromPin0 = extck; // R8
    end
endmodule : term_decode
`default_nettype wire

// ==== src/two_bit_input_port_osc_share.sv ====
// Two-bit input port with termination selects and oscillator pin sharing
// Functional notes
// (R1) Input level register reads pin levels
// (R2) Input level register is read-only
// (R3) Select pairs choose hiz, pull-down, pull-up
// (R4) Select registers reset to zero
// (R5) Oscillator mode alone switches pin use
// (R6) Crystal mode takes both pins
// (R7) Crystal mode drives pin one
// (R8) External clock mode clocks from pin zero
// (R9) External clock mode keeps pin one readable
// (R10) Software sets hiz before crystal use
// (R11) Software sets pin zero hiz for clock
// (R12) Unused high bits read zero
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module two_bit_input_port_osc_share (
    // Clock and reset
    input  wire  logic                       clk,
    input  wire  logic                       arst_n,
    // APB slave
    input  wire  logic                       psel,
    input  wire  logic                       penable,
    input  wire  logic                       pwrite,
    input  wire  logic [port_in_pkg::ADDR_W-1:0] paddr,
    input  wire  logic [31:0]                pwdata,
    input  wire  logic [3:0]                 pstrb,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Oscillator mode field from frequency control register
    input  wire  logic [1:0]                 hsOscModeSel,
    // Pins
    input  wire  logic [1:0]                 pinIn,
    output logic                             pinOneOut,
    output logic                             pinOneOe_n,
    output logic [1:0]                       pullUpEn,
    output logic [1:0]                       pullDownEn,
    // Oscillator side
    input  wire  logic                       oscDriveLevel,
    output logic                             extClkOut
);
    // ==========================================================
    // State
    typedef struct packed {
        port_in_pkg::term_regs_t regs;
        logic [31:0]             rdata;
        logic                    slverr;
    } st_t;
    st_t state_ff;
    st_t nxt_state;

    port_in_pkg::apb_req_t  req;
    port_in_pkg::pad_ctrl_t pad;
    logic [1:0]             level;
    logic                   access;
    logic                   hitLevel;
    logic                   hitLow;
    logic                   hitHigh;

    assign req = '{psel, penable, pwrite, paddr, pwdata};
    assign access   = req.psel && !req.penable;
    assign hitLevel = (req.paddr == port_in_pkg::ADDR_INPUT_LEVEL);
    assign hitLow   = (req.paddr == port_in_pkg::ADDR_TERM_LOW);
    assign hitHigh  = (req.paddr == port_in_pkg::ADDR_TERM_HIGH);

    // ==========================================================
    // Decode and sampling
    term_decode u_dec (
        .regs         (state_ff.regs),
        .hsOscModeSel (hsOscModeSel), // R5
        .pad          (pad)
    );

    level_sync u_lvl (
        .clk     (clk),
        .arst_n  (arst_n),
        .pinIn   (pinIn),
        .inputEn (pad.inputEn), // R9
        .level   (level)
    );

    // ==========================================================
    // Register file; answer is taken in setup, ready in access
    always_comb begin
        nxt_state = state_ff;
        if (access) begin
            nxt_state.rdata  = port_in_pkg::READ_ZERO; // R12
            nxt_state.slverr = !(hitLevel || hitLow || hitHigh);
            if (req.pwrite) begin
                // Writes to the level register are dropped
                if (hitLow && pstrb[0]) begin
                    nxt_state.regs.termLow = req.pwdata[1:0]; // R3
                end
                if (hitHigh && pstrb[0]) begin
                    nxt_state.regs.termHigh = req.pwdata[1:0]; // R3
                end
                if (hitLevel) begin
                    nxt_state.slverr = 1'b1; // R2
                end
            end else begin
                if (hitLevel) begin
                    nxt_state.rdata[1:0] = level; // R1
                end
                if (hitLow) begin
                    nxt_state.rdata[1:0] = state_ff.regs.termLow;
                end
                if (hitHigh) begin
                    nxt_state.rdata[1:0] = state_ff.regs.termHigh;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff.regs   <= {port_in_pkg::TERM_RESET[1:0], port_in_pkg::TERM_RESET[1:0]}; // R4
            state_ff.rdata  <= port_in_pkg::READ_ZERO;
            state_ff.slverr <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pready     = psel && penable;
    assign prdata     = state_ff.rdata;
    assign pslverr    = pready && state_ff.slverr;
    assign pullUpEn   = pad.pullUpEn;
    assign pullDownEn = pad.pullDownEn;
    assign pinOneOe_n = !pad.drivePinOne;                  // R7
    assign pinOneOut  = pad.drivePinOne && oscDriveLevel;  // R7
    assign extClkOut  = pad.clkFromPin0 && pinIn[port_in_pkg::PIN_ZERO_BIT]; // R8

    // ==========================================================
    // Checks
    AST_XTAL_NO_PULL: assert property (@(posedge clk) disable iff (!arst_n)
        hsOscModeSel == port_in_pkg::OSC_MODE_XTAL |-> (pullUpEn | pullDownEn) == 2'b00)
        else $error("pull active in crystal mode"); // R6
    AST_XTAL_DRIVE: assert property (@(posedge clk) disable iff (!arst_n)
        (hsOscModeSel == port_in_pkg::OSC_MODE_XTAL) == !pinOneOe_n)
        else $error("pin one drive mismatch"); // R7
    AST_EXT_CLK: assert property (@(posedge clk) disable iff (!arst_n)
        hsOscModeSel == port_in_pkg::OSC_MODE_EXTCK |-> extClkOut == pinIn[0])
        else $error("external clock not from pin zero"); // R8
    AST_PIN1_READ: assert property (@(posedge clk) disable iff (!arst_n)
        $stable(hsOscModeSel) && hsOscModeSel == port_in_pkg::OSC_MODE_EXTCK
        |=> level[1] == $past(pinIn[1]))
        else $error("pin one unreadable in clock mode"); // R9
    AST_READ_LEVEL: assert property (@(posedge clk) disable iff (!arst_n)
        access && !pwrite && hitLevel |=> prdata == {30'h0, $past(level)})
        else $error("level read wrong"); // R1
    AST_RO: assert property (@(posedge clk) disable iff (!arst_n)
        access && pwrite && hitLevel |=> $stable(state_ff.regs))
        else $error("level write changed state"); // R2
    AST_PULLUP: assert property (@(posedge clk) disable iff (!arst_n)
        hsOscModeSel == port_in_pkg::OSC_MODE_PORT |->
        pullUpEn == (state_ff.regs.termHigh & ~state_ff.regs.termLow))
        else $error("pull-up decode wrong"); // R3
    AST_PULLDN: assert property (@(posedge clk) disable iff (!arst_n)
        hsOscModeSel == port_in_pkg::OSC_MODE_PORT |->
        pullDownEn == (~state_ff.regs.termHigh & state_ff.regs.termLow))
        else $error("pull-down decode wrong"); // R3
    AST_HIGH_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
        pready |-> prdata[31:2] == 30'h0)
        else $error("upper read bits nonzero"); // R12
    AST_RESET_HIZ: assert property (@(posedge clk)
        $rose(arst_n) |-> state_ff.regs == '0)
        else $error("selects not cleared by reset"); // R4

    // ==========================================================
    // Register access checks

    AST_LOW_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // R3
        access && pwrite && hitLow && pstrb[0]
        |=> state_ff.regs.termLow == $past(pwdata[1:0]))
        else $error("low select write lost");

    AST_HIGH_WRITE: assert property (@(posedge clk) disable iff (!arst_n) // R3
        access && pwrite && hitHigh && pstrb[0]
        |=> state_ff.regs.termHigh == $past(pwdata[1:0]))
        else $error("high select write lost");

    AST_LOW_READ: assert property (@(posedge clk) disable iff (!arst_n) // R3
        access && !pwrite && hitLow
        |=> prdata == {30'h0, $past(state_ff.regs.termLow)})
        else $error("low select read wrong");

    AST_HIGH_READ: assert property (@(posedge clk) disable iff (!arst_n) // R3
        access && !pwrite && hitHigh
        |=> prdata == {30'h0, $past(state_ff.regs.termHigh)})
        else $error("high select read wrong");

    AST_RO_ERR: assert property (@(posedge clk) disable iff (!arst_n) // R2
        pready && pwrite && hitLevel
        |-> pslverr)
        else $error("level write not refused");

    AST_UNMAPPED_ERR: assert property (@(posedge clk) disable iff (!arst_n) // R12
        pready && !(hitLevel || hitLow || hitHigh)
        |-> pslverr)
        else $error("unmapped access not refused");

    AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (!arst_n) // R12
        pready && !(hitLevel || hitLow || hitHigh)
        |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");

    AST_MAPPED_NO_ERR: assert property (@(posedge clk) disable iff (!arst_n) // R3
        pready && (hitLow || hitHigh)
        |-> !pslverr)
        else $error("select access refused");

    AST_SLVERR_QUIET: assert property (@(posedge clk) disable iff (!arst_n) // R2
        !pready
        |-> !pslverr)
        else $error("error outside access phase");

    AST_READ_STABLE: assert property (@(posedge clk) disable iff (!arst_n) // R1
        !access
        |=> $stable(prdata))
        else $error("read data moved without setup");

    AST_REGS_HOLD: assert property (@(posedge clk) disable iff (!arst_n) // R3
        !(access && pwrite)
        |=> $stable(state_ff.regs))
        else $error("selects moved without write");

    // ==========================================================
    // Reset checks

    AST_RESET_PRDATA: assert property (@(posedge clk) // R4
        $rose(arst_n)
        |-> prdata == 32'h00000000)
        else $error("read data not cleared by reset");

    AST_RESET_PULLS: assert property (@(posedge clk) // R4
        $rose(arst_n) && hsOscModeSel == port_in_pkg::OSC_MODE_PORT
        |-> (pullUpEn | pullDownEn) == 2'b00)
        else $error("pull active after reset");

    // ==========================================================
    // Pin use checks

    AST_PORT_INPUTS: assert property (@(posedge clk) disable iff (!arst_n) // R1
        hsOscModeSel == port_in_pkg::OSC_MODE_PORT
        |-> pad.inputEn == 2'b11)
        else $error("port mode input disabled");

    AST_PORT_LEVEL: assert property (@(posedge clk) disable iff (!arst_n) // R1
        hsOscModeSel == port_in_pkg::OSC_MODE_PORT
        |=> level == $past(pinIn))
        else $error("port mode level wrong");

    AST_NO_BOTH_PULLS: assert property (@(posedge clk) disable iff (!arst_n) // R3
        1'b1
        |-> (pullUpEn & pullDownEn) == 2'b00)
        else $error("pull-up and pull-down together");

    AST_MODE3_PORT: assert property (@(posedge clk) disable iff (!arst_n) // R5
        hsOscModeSel == 2'b11
        |-> pinOneOe_n && !extClkOut)
        else $error("reserved mode took pins");

    AST_EXT_PULLUP: assert property (@(posedge clk) disable iff (!arst_n) // R5
        hsOscModeSel == port_in_pkg::OSC_MODE_EXTCK
        |-> pullUpEn == (state_ff.regs.termHigh & ~state_ff.regs.termLow))
        else $error("pull-up lost in clock mode");

    AST_EXT_PULLDN: assert property (@(posedge clk) disable iff (!arst_n) // R5
        hsOscModeSel == port_in_pkg::OSC_MODE_EXTCK
        |-> pullDownEn == (~state_ff.regs.termHigh & state_ff.regs.termLow))
        else $error("pull-down lost in clock mode");

    AST_XTAL_NO_INPUT: assert property (@(posedge clk) disable iff (!arst_n) // R6
        hsOscModeSel == port_in_pkg::OSC_MODE_XTAL
        |-> pad.inputEn == 2'b00)
        else $error("input left on in crystal mode");

    AST_XTAL_LEVEL_ZERO: assert property (@(posedge clk) disable iff (!arst_n) // R6
        hsOscModeSel == port_in_pkg::OSC_MODE_XTAL
        |=> level == 2'b00)
        else $error("resonator swing seen as level");

    AST_XTAL_OUT_LEVEL: assert property (@(posedge clk) disable iff (!arst_n) // R7
        hsOscModeSel == port_in_pkg::OSC_MODE_XTAL
        |-> pinOneOut == oscDriveLevel)
        else $error("resonator drive wrong");

    AST_PORT_NO_DRIVE: assert property (@(posedge clk) disable iff (!arst_n) // R7
        hsOscModeSel != port_in_pkg::OSC_MODE_XTAL
        |-> !pinOneOut)
        else $error("pin one driven outside crystal mode");

    AST_NO_EXT_CLK: assert property (@(posedge clk) disable iff (!arst_n) // R8
        hsOscModeSel != port_in_pkg::OSC_MODE_EXTCK
        |-> !extClkOut)
        else $error("clock passed outside clock mode");

    AST_EXT_PIN0_ZERO: assert property (@(posedge clk) disable iff (!arst_n) // R8
        hsOscModeSel == port_in_pkg::OSC_MODE_EXTCK
        |=> level[0] == 1'b0)
        else $error("clock pin seen as level");

    AST_EXT_PIN1_INPUT: assert property (@(posedge clk) disable iff (!arst_n) // R9
        hsOscModeSel == port_in_pkg::OSC_MODE_EXTCK
        |-> pad.inputEn == 2'b10)
        else $error("pin one input lost in clock mode");
endmodule : two_bit_input_port_osc_share
`default_nettype wire

// ==== verification/pin_model.sv ====
// Board-side model of the two shared pins
`timescale 1ns/100ps
`default_nettype none
module pin_model (
    // Clock
    input  wire logic       clk,
    // Board drive
    input  wire logic [1:0] extLevel,
    input  wire logic [1:0] extDriven,
    // Device pad control
    input  wire logic       pinOneOut,
    input  wire logic       pinOneOe_n,
    input  wire logic [1:0] pullUpEn,
    input  wire logic [1:0] pullDownEn,
    // Levels seen at the pads
    output logic [1:0]      pinIn
);
    // A floating pad toggles so a stale value never looks valid
    logic [1:0] floatLvl = 2'b01;
    always_ff @(posedge clk) begin
        floatLvl <= ~floatLvl;
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (extDriven[i]) pinIn[i] = extLevel[i];
            else if (pullUpEn[i]) pinIn[i] = 1'b1;
            else if (pullDownEn[i]) pinIn[i] = 1'b0;
            else pinIn[i] = floatLvl[i];
        end
        if (!pinOneOe_n) pinIn[1] = pinOneOut;
    end
endmodule : pin_model
`default_nettype wire

// ==== verification/tb_two_bit_input_port_osc_share.sv ====
// Self-checking bench for the two-bit input port
`timescale 1ns/100ps
`default_nettype none
module tb_two_bit_input_port_osc_share;
    `define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
        $display("Error at %0t: got %h expected %h", $time, g, e); end end
    logic                           clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic                           pinOneOut, pinOneOe_n, oscDriveLevel, extClkOut;
    logic [port_in_pkg::ADDR_W-1:0] paddr;
    logic [31:0]                    pwdata, prdata, rd;
    logic [1:0]                     hsOscModeSel, pinIn, pullUpEn, pullDownEn;
    logic [1:0]                     extLevel, extDriven;
    int                             miscompares = 0;
    int                             nCompared = 0;

    two_bit_input_port_osc_share uut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .hsOscModeSel, .pinIn,
        .pinOneOut, .pinOneOe_n, .pullUpEn, .pullDownEn, .oscDriveLevel, .extClkOut);
    pin_model pins (.clk, .extLevel, .extDriven, .pinOneOut, .pinOneOe_n, .pullUpEn,
        .pullDownEn, .pinIn);

    // ==========================================================
    // Bus tasks
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // Only the watchdog ends a wait that never gets an answer
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdChk(input logic [17:0] a, input logic [31:0] e, input logic eErr);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
        `CHK(err, eErr)
    endtask : rdChk

    // ==========================================================
    // Scenarios
    task automatic scReset;
        `CHK({pullUpEn, pullDownEn}, 4'h0)
        rdChk(port_in_pkg::ADDR_TERM_LOW, 32'h00000000, 1'b0);
        rdChk(port_in_pkg::ADDR_TERM_HIGH, 32'h00000000, 1'b0);
    endtask : scReset
    task automatic scTerm;
        logic [1:0] c, lo, hi;
        for (int k = 0; k < 4; k++) begin
            c = k[1:0];
            hi = {~c[1], c[1]};
            lo = {~c[0], c[0]};
            apb(1'b1, port_in_pkg::ADDR_TERM_LOW, {30'h3fffffff, lo});
            apb(1'b1, port_in_pkg::ADDR_TERM_HIGH, {30'h3fffffff, hi});
            `CHK(pullUpEn, hi & ~lo)
            `CHK(pullDownEn, lo & ~hi)
            rdChk(port_in_pkg::ADDR_TERM_LOW, {30'h0, lo}, 1'b0);
            rdChk(port_in_pkg::ADDR_TERM_HIGH, {30'h0, hi}, 1'b0);
            // Floating pins toggle, so only the pulled bits are predictable
            apb(1'b0, port_in_pkg::ADDR_INPUT_LEVEL, 32'h00000000);
            `CHK(rd[31:2], 30'h0)
            `CHK(err, 1'b0)
            `CHK(rd[1:0] & (pullUpEn | pullDownEn), pullUpEn)
        end
        apb(1'b1, port_in_pkg::ADDR_TERM_LOW, 32'h00000000);
        apb(1'b1, port_in_pkg::ADDR_TERM_HIGH, 32'h00000000);
    endtask : scTerm
    task automatic scLevel;
        extDriven <= 2'b11;
        for (int v = 0; v < 4; v++) begin
            extLevel <= v[1:0];
            repeat (2) @(posedge clk);
            rdChk(port_in_pkg::ADDR_INPUT_LEVEL, {30'h0, v[1:0]}, 1'b0);
        end
        apb(1'b1, port_in_pkg::ADDR_INPUT_LEVEL, 32'h00000000);
        `CHK(err, 1'b1)
        rdChk(port_in_pkg::ADDR_INPUT_LEVEL, 32'h00000003, 1'b0);
        rdChk(18'h3c824, 32'h00000000, 1'b1);
    endtask : scLevel
    task automatic scOsc;
        // Selects already back to high impedance before the pins change use
        hsOscModeSel <= port_in_pkg::OSC_MODE_XTAL;
        extDriven <= 2'b01;
        extLevel <= 2'b11;
        for (int d = 0; d < 2; d++) begin
            oscDriveLevel <= d[0];
            repeat (2) @(posedge clk);
            `CHK({pinOneOe_n, pinOneOut}, {1'b0, d[0]})
            rdChk(port_in_pkg::ADDR_INPUT_LEVEL, 32'h00000000, 1'b0);
        end
        hsOscModeSel <= port_in_pkg::OSC_MODE_EXTCK;
        extDriven <= 2'b11;
        for (int v = 0; v < 4; v++) begin
            extLevel <= v[1:0];
            repeat (2) @(posedge clk);
            `CHK(extClkOut, v[0])
            `CHK(pinOneOe_n, 1'b1)
            rdChk(port_in_pkg::ADDR_INPUT_LEVEL, {30'h0, v[1], 1'b0}, 1'b0);
        end
        hsOscModeSel <= 2'b11;
        repeat (2) @(posedge clk);
        `CHK({extClkOut, pinOneOe_n}, 2'b01)
        rdChk(port_in_pkg::ADDR_INPUT_LEVEL, 32'h00000003, 1'b0);
    endtask : scOsc

    // ==========================================================
    // Run control
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #400000;
        miscompares++;
        end_of_test;
    end
    initial begin
        {arst_n, psel, penable, pwrite, oscDriveLevel} = 5'h00;
        paddr = '0;
        pwdata = 32'h00000000;
        hsOscModeSel = port_in_pkg::OSC_MODE_PORT;
        extLevel = 2'b00;
        extDriven = 2'b00;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        scReset;
        scTerm;
        scLevel;
        scOsc;
        end_of_test;
    end
endmodule : tb_two_bit_input_port_osc_share
`default_nettype wire
